/* File: rtl/sdpci_top.sv */
// Purpose: Device-side pin command interface of a four-bank x16 SDRAM.
// Assumes: Pins are synchronous to clk; the core answers reads in the same cycle.
// Notes:   The data pins are split into dq_in, dq_out and per-lane dq_oe.
//
// Functional notes
// (RULE1) Sample every input on rising clk edge.
// (RULE2) Clock advances burst counter and output registers.
// (RULE3) Clock enable high runs, low stops internal clock.
// (RULE4) Enable low: power-down, self refresh or suspend.
// (RULE5) In low-power modes enable acts without waiting; the code samples it on the rising clk edge like any other input.
// (RULE6) Low-power modes ignore all inputs but enable.
// (RULE7) Controller may tie clock enable high.
// (RULE8) Chip select low decodes; high ignores commands.
// (RULE9) Running bursts and masking continue while deselected.
// (RULE10) Command comes from four strobes at edge.
// (RULE11) Masked write lanes discard their input data.
// (RULE12) Read mask floats output two clocks later.
// (RULE13) Lower mask lane 0-7, upper 8-15.
// (RULE14) Bank inputs pick target of bank commands.
// (RULE15) Bank inputs carry mode op-code bits.
// (RULE16) Activate captures thirteen-bit row address.
// (RULE17) x16 column address uses bits 0 to 8.
// (RULE18) Address bit 10 requests auto precharge.
// (RULE19) Precharge bit 10 high closes all banks.
// (RULE20) Address inputs carry mode register op-code.
// (RULE21) Sixteen-bit data bus, both directions.
// (RULE22) Controller floats bus while device may drive.
`timescale 1ns/1ps
`default_nettype none
`include "sdpci_map.svh"

module sdpci_top
  import sdpci_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Command pins
  input  wire sdpci_pins_t              pins,
  // Data pins
  input  wire logic [`SDPCI_DQ_W-1:0]   dq_in,
  output var  logic [`SDPCI_DQ_W-1:0]   dq_out,
  output var  logic [`SDPCI_LANES-1:0]  dq_oe,
  // Memory core side
  output var  sdpci_core_t              core,
  input  wire logic [`SDPCI_DQ_W-1:0]   core_rd_data,
  // Status
  output var  logic [`SDPCI_MR_W-1:0]   mode_reg,
  output var  sdpci_pwr_t               pwr_state,
  output var  logic [`SDPCI_BANKS-1:0]  bank_open
);

  // ----------------------------------------------------------------------
  // Bank trackers
  // ----------------------------------------------------------------------
  logic [`SDPCI_ROW_W-1:0] bank_row [`SDPCI_BANKS];
  logic [`SDPCI_BANKS-1:0] act_v;
  logic [`SDPCI_BANKS-1:0] pre_v;

  for (genvar b = 0; b < `SDPCI_BANKS; b++) begin : g_bank
    sdpci_bank #(
      .ROW_W (`SDPCI_ROW_W)
    ) u_bank (
      .clk    (clk),
      .rst_n  (rst_n),
      .act    (act_v[b]),
      .pre    (pre_v[b]),
      .row_in (pins.addr),
      .open_r (bank_open[b]),
      .row_r  (bank_row[b])
    );
  end

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  sdpci_st_t               st_r;
  sdpci_st_t               st_nxt;
  logic [3:0]              cmd;
  logic [`SDPCI_LANES-1:0] mask;
  logic                    run;
  logic [2:0]              bl_code;
  logic [`SDPCI_LEN_W-1:0] blen;
  logic                    busy;
  logic                    idle_after;
  logic                    rd_v;

  // Chip select is part of the code, so a deselected cycle matches nothing.
  assign cmd     = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n}; // RULE10 RULE8
  assign mask    = {pins.upper_byte_mask, pins.lower_byte_mask}; // RULE13
  assign run     = (st_r.pwr == PWR_RUN);
  assign bl_code = st_r.mode[`SDPCI_MR_BL_MSB:`SDPCI_MR_BL_LSB];

  // Unsupported burst codes fall back to a single beat.
  always_comb begin
    if (bl_code == `SDPCI_BL_PAGE) begin
      blen = `SDPCI_LEN_PAGE;
    end else if (bl_code <= `SDPCI_BL_MAX) begin
      blen = `SDPCI_LEN_ONE << bl_code;
    end else begin
      blen = `SDPCI_LEN_ONE;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt            = st_r;
    act_v             = '0;
    pre_v             = '0;
    busy              = 1'b0;
    idle_after        = 1'b1;
    rd_v              = 1'b0;
    st_nxt.core.wr_en  = 1'b0;
    st_nxt.core.ref_en = 1'b0;
    // A held read beat is re-issued after a suspend; reads have no side effect.
    st_nxt.core.rd_en  = run ? 1'b0 : st_r.core.rd_en;
    case (st_r.pwr)
      PWR_RUN: begin
        if (st_r.burst_left != '0) begin
          st_nxt.burst_left   = st_r.burst_left - `SDPCI_LEN_ONE; // RULE2 RULE9
          st_nxt.col          = st_r.col + `SDPCI_COL_ONE; // RULE2
          st_nxt.core.bank    = st_r.bank;
          st_nxt.core.row     = bank_row[st_r.bank];
          st_nxt.core.col     = st_r.col;
          st_nxt.core.wr_en   = st_r.wr_burst;
          st_nxt.core.rd_en   = !st_r.wr_burst;
          st_nxt.core.wr_data = dq_in; // RULE21
          st_nxt.core.wr_be   = ~mask; // RULE11 RULE9
          if (st_r.ap && (st_r.burst_left == `SDPCI_LEN_ONE)) begin
            pre_v[st_r.bank] = 1'b1; // RULE18
            st_nxt.ap        = 1'b0;
          end
        end
        case (cmd)
          `SDPCI_CMD_RD, `SDPCI_CMD_WR: begin
            st_nxt.core.bank    = pins.ba; // RULE14
            st_nxt.core.row     = bank_row[pins.ba];
            st_nxt.core.col     = pins.addr[`SDPCI_COL_W-1:0]; // RULE17
            st_nxt.core.wr_en   = (cmd == `SDPCI_CMD_WR);
            st_nxt.core.rd_en   = (cmd == `SDPCI_CMD_RD);
            st_nxt.core.wr_data = dq_in; // RULE21
            st_nxt.core.wr_be   = ~mask; // RULE11
            st_nxt.wr_burst     = (cmd == `SDPCI_CMD_WR);
            st_nxt.bank         = pins.ba;
            st_nxt.col          = pins.addr[`SDPCI_COL_W-1:0] + `SDPCI_COL_ONE; // RULE17
            st_nxt.burst_left   = blen - `SDPCI_LEN_ONE;
            st_nxt.ap           = pins.addr[`SDPCI_AP_BIT] && (blen != `SDPCI_LEN_ONE);
            if (pins.addr[`SDPCI_AP_BIT] && (blen == `SDPCI_LEN_ONE)) begin
              pre_v[pins.ba] = 1'b1; // RULE18
            end
          end
          `SDPCI_CMD_BST: begin
            st_nxt.burst_left = '0;
          end
          `SDPCI_CMD_ACT: begin
            act_v[pins.ba] = 1'b1; // RULE14 RULE16
          end
          `SDPCI_CMD_PRE: begin
            if (pins.addr[`SDPCI_AP_BIT]) begin
              pre_v = '1; // RULE19
            end else begin
              pre_v = `SDPCI_BANK_ONE << pins.ba; // RULE19 RULE14
            end
          end
          `SDPCI_CMD_REF: begin
            st_nxt.core.ref_en = pins.cke;
          end
          `SDPCI_CMD_LMR: begin
            st_nxt.mode = {pins.ba, pins.addr}; // RULE15 RULE20
          end
          default: begin
          end
        endcase
        // Read return path: CAS latency two or three.
        rd_v             = (st_r.mode[`SDPCI_MR_CL_MSB:`SDPCI_MR_CL_LSB] == `SDPCI_CL3);
        st_nxt.rd_hold   = core_rd_data;
        st_nxt.rd_hold_v = st_r.core.rd_en;
        st_nxt.dq_out    = rd_v ? st_r.rd_hold : core_rd_data; // RULE2
        st_nxt.m1        = mask;
        st_nxt.m2        = st_r.m1;
        st_nxt.dq_oe     = {`SDPCI_LANES{rd_v ? st_r.rd_hold_v : st_r.core.rd_en}}
                           & ~st_r.m2; // RULE12 RULE13
        busy       = (st_nxt.burst_left != '0) || st_nxt.core.wr_en || st_nxt.core.rd_en
                     || st_r.core.rd_en || st_r.rd_hold_v;
        idle_after = ~|((bank_open | act_v) & ~pre_v);
        if (!pins.cke) begin
          if ((cmd == `SDPCI_CMD_REF) && idle_after && !busy) begin
            st_nxt.pwr = PWR_SELF_REF; // RULE4
          end else if (busy) begin
            st_nxt.pwr = PWR_SUSPEND; // RULE3 RULE4
          end else if (!idle_after) begin
            st_nxt.pwr = PWR_ACT_PD; // RULE4
          end else begin
            st_nxt.pwr = PWR_PRE_PD; // RULE4
          end
        end
      end
      PWR_SUSPEND: begin
        // All state but the write and refresh strobes holds; the clock comes back one edge after enable rises.
        if (pins.cke) begin
          st_nxt.pwr = PWR_RUN; // RULE3
        end
      end
      default: begin
        // Input buffers are off, so only the enable pin is looked at.
        st_nxt.dq_oe = '0; // RULE6
        if (pins.cke) begin
          st_nxt.pwr = PWR_RUN; // RULE5
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt; // RULE1
    end
  end

  assign dq_out    = st_r.dq_out;
  assign dq_oe     = st_r.dq_oe; // RULE22
  assign core      = st_r.core;
  assign mode_reg  = st_r.mode;
  assign pwr_state = st_r.pwr;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_mask_lo;
    run && pins.lower_byte_mask ##1 run ##1 run;
  endsequence

  sequence s_mask_hi;
    run && pins.upper_byte_mask ##1 run ##1 run;
  endsequence

  chk_read_hiz_lo: assert property ( // RULE12
    s_mask_lo |=> !st_r.dq_oe[0])
    else $error("lower lane driven after masked read cycle");

  chk_read_hiz_hi: assert property ( // RULE13
    s_mask_hi |=> !st_r.dq_oe[1])
    else $error("upper lane driven after masked read cycle");

  chk_cs_ignore: assert property ( // RULE8
    run && pins.cs_n && (st_r.burst_left == '0)
    |=> !st_r.core.wr_en && !st_r.core.rd_en && $stable(st_r.mode))
    else $error("deselected cycle produced an access");

  chk_write_mask: assert property ( // RULE11
    run && (cmd == `SDPCI_CMD_WR)
    |=> st_r.core.wr_en && (st_r.core.wr_be == ~$past(mask)))
    else $error("write lane enables do not follow the masks");

  chk_burst_keep: assert property ( // RULE9
    run && pins.cs_n && st_r.wr_burst && (st_r.burst_left != '0)
    |=> st_r.core.wr_en)
    else $error("write burst stopped while deselected");

  chk_mode_load: assert property ( // RULE15 RULE20
    run && (cmd == `SDPCI_CMD_LMR)
    |=> st_r.mode == $past({pins.ba, pins.addr}))
    else $error("mode register not loaded from bank and address");

  chk_act_open: assert property ( // RULE16 RULE14
    run && (cmd == `SDPCI_CMD_ACT)
    |=> bank_open[$past(pins.ba)] && (bank_row[$past(pins.ba)] == $past(pins.addr)))
    else $error("activate did not open the addressed row");

  chk_pre_all: assert property ( // RULE19
    run && (cmd == `SDPCI_CMD_PRE) && pins.addr[`SDPCI_AP_BIT]
    |=> bank_open == '0)
    else $error("precharge all left a bank open");

  chk_suspend: assert property ( // RULE4
    run && !pins.cke && pins.cs_n && (st_r.burst_left != '0)
    |=> (st_r.pwr == PWR_SUSPEND))
    else $error("burst did not enter clock suspend");

  chk_pd_hold: assert property ( // RULE6
    (st_r.pwr == PWR_PRE_PD) && !pins.cke
    |=> (st_r.pwr == PWR_PRE_PD) && $stable(st_r.mode) && !st_r.core.wr_en)
    else $error("power-down reacted to inputs");

  chk_pd_exit: assert property ( // RULE5
    ((st_r.pwr == PWR_PRE_PD) || (st_r.pwr == PWR_ACT_PD) || (st_r.pwr == PWR_SELF_REF))
    && pins.cke |=> run)
    else $error("low-power mode did not exit on enable high");

endmodule : sdpci_top

`default_nettype wire

/* File: rtl/sdpci_map.svh */
// Purpose: Named constants for the SDRAM pin command interface.
// Assumes: x16 organisation, four banks.
// Notes:   Definitions only.
`ifndef SDPCI_MAP_SVH
`define SDPCI_MAP_SVH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define SDPCI_ROW_W    13
`define SDPCI_COL_W    9
`define SDPCI_BANK_W   2
`define SDPCI_BANKS    4
`define SDPCI_DQ_W     16
`define SDPCI_LANES    2
`define SDPCI_MR_W     15
`define SDPCI_LEN_W    10
`define SDPCI_AP_BIT   10

// ----------------------------------------------------------------------
// Command codes, ordered {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------------------------------------
`define SDPCI_CMD_LMR  4'h0
`define SDPCI_CMD_REF  4'h1
`define SDPCI_CMD_PRE  4'h2
`define SDPCI_CMD_ACT  4'h3
`define SDPCI_CMD_WR   4'h4
`define SDPCI_CMD_RD   4'h5
`define SDPCI_CMD_BST  4'h6
`define SDPCI_CMD_NOP  4'h7

// ----------------------------------------------------------------------
// Mode register fields and burst counts
// ----------------------------------------------------------------------
`define SDPCI_MR_BL_LSB 0
`define SDPCI_MR_BL_MSB 2
`define SDPCI_MR_CL_LSB 4
`define SDPCI_MR_CL_MSB 6
`define SDPCI_BL_MAX    3'h3
`define SDPCI_BL_PAGE   3'h7
`define SDPCI_CL3       3'h3
`define SDPCI_LEN_ONE   10'h001
`define SDPCI_LEN_PAGE  10'h200
`define SDPCI_COL_ONE   9'h001
`define SDPCI_BANK_ONE  4'h1

`endif

/* File: rtl/sdpci_pkg.sv */
// Purpose: Types shared by the SDRAM pin command interface.
// Assumes: Constants come from sdpci_map.svh.
// Notes:   Structs carry the pin group, the core request and the state.
`include "sdpci_map.svh"

package sdpci_pkg;

  // ----------------------------------------------------------------------
  // Power and clock states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_RUN,
    PWR_SUSPEND,
    PWR_PRE_PD,
    PWR_ACT_PD,
    PWR_SELF_REF
  } sdpci_pwr_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                     cke;
    logic                     cs_n;
    logic                     ras_n;
    logic                     cas_n;
    logic                     we_n;
    logic [`SDPCI_BANK_W-1:0] ba;
    logic [`SDPCI_ROW_W-1:0]  addr;
    logic                     upper_byte_mask;
    logic                     lower_byte_mask;
  } sdpci_pins_t;

  typedef struct packed {
    logic                     wr_en;
    logic                     rd_en;
    logic                     ref_en;
    logic [`SDPCI_BANK_W-1:0] bank;
    logic [`SDPCI_ROW_W-1:0]  row;
    logic [`SDPCI_COL_W-1:0]  col;
    logic [`SDPCI_DQ_W-1:0]   wr_data;
    logic [`SDPCI_LANES-1:0]  wr_be;
  } sdpci_core_t;

  typedef struct packed {
    sdpci_pwr_t               pwr;
    logic [`SDPCI_MR_W-1:0]   mode;
    logic [`SDPCI_LEN_W-1:0]  burst_left;
    logic [`SDPCI_COL_W-1:0]  col;
    logic [`SDPCI_BANK_W-1:0] bank;
    logic                     wr_burst;
    logic                     ap;
    sdpci_core_t              core;
    logic [`SDPCI_DQ_W-1:0]   rd_hold;
    logic                     rd_hold_v;
    logic [`SDPCI_LANES-1:0]  m1;
    logic [`SDPCI_LANES-1:0]  m2;
    logic [`SDPCI_DQ_W-1:0]   dq_out;
    logic [`SDPCI_LANES-1:0]  dq_oe;
  } sdpci_st_t;

endpackage : sdpci_pkg

/* File: rtl/sdpci_bank.sv */
// Purpose: Open-row tracker for one bank.
// Assumes: Activate and precharge never arrive together for one bank.
// Notes:   One instance per bank.
`timescale 1ns/1ps
`default_nettype none

module sdpci_bank #(
  parameter int ROW_W = 13
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Commands for this bank
  input  wire logic             act,
  input  wire logic             pre,
  input  wire logic [ROW_W-1:0] row_in,
  // Bank state
  output var  logic             open_r,
  output var  logic [ROW_W-1:0] row_r
);

  typedef struct packed {
    logic             open;
    logic [ROW_W-1:0] row;
  } sdpci_bank_st_t;

  sdpci_bank_st_t st_r;
  sdpci_bank_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (act) begin
      st_nxt.open = 1'b1; // RULE16
      st_nxt.row  = row_in; // RULE16
    end else if (pre) begin
      st_nxt.open = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign open_r = st_r.open;
  assign row_r  = st_r.row;

endmodule : sdpci_bank

`default_nettype wire

/* File: sim/sdpci_ctl_model.sv */
// Purpose: Behavioural memory controller that drives the device pins.
// Assumes: Pins change on the falling clock edge, half a cycle before sampling.
// Notes:   A released data lane shows the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
`include "sdpci_map.svh"

module sdpci_ctl_model
  import sdpci_pkg::*;
(
  // Clock
  input  wire logic                     clk,
  // Command pins
  output var  sdpci_pins_t              pins,
  // Data bus
  input  wire logic [`SDPCI_DQ_W-1:0]   dq_dev,
  input  wire logic [`SDPCI_LANES-1:0]  dq_oe,
  output var  logic [`SDPCI_DQ_W-1:0]   dq_wire
);
  logic                   drv_en;
  logic [`SDPCI_DQ_W-1:0] drv_data;
  logic [`SDPCI_DQ_W-1:0] last;

  // ----------------------------------------------------------------------
  // Bus resolution
  // ----------------------------------------------------------------------
  // A floating lane toggles so a stale value can never pass for data.
  always_comb begin
    for (int i = 0; i < `SDPCI_LANES; i++) begin
      dq_wire[i*8+:8] = dq_oe[i] ? dq_dev[i*8+:8] :
                        (drv_en ? drv_data[i*8+:8] : ~last[i*8+:8]);
    end
  end

  always @(posedge clk) begin
    last <= dq_wire;
  end

  initial begin
    last <= 16'h0000;
    drv_en = 1'b0;
    drv_data = 16'h0000;
    pins = '0;
    pins.cke = 1'b1;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = `SDPCI_CMD_NOP;
  end

  // ----------------------------------------------------------------------
  // Requests
  // ----------------------------------------------------------------------
  task automatic issue(input logic cke, input logic [3:0] cmd, input logic [1:0] ba,
                       input logic [12:0] addr, input logic [1:0] mask);
    @(negedge clk);
    pins.cke = cke;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = cmd;
    pins.ba = ba;
    pins.addr = addr;
    {pins.upper_byte_mask, pins.lower_byte_mask} = mask;
  endtask : issue

  // Writes drive the bus; anything else must leave it free for the device.
  task automatic data(input logic en, input logic [15:0] d);
    drv_en = en;
    drv_data = d;
  endtask : data
endmodule : sdpci_ctl_model
`default_nettype wire

/* File: sim/sdpci_tb_top.sv */
// Purpose: Self-checking bench for the SDRAM pin command interface.
// Assumes: Mode is burst of two, read latency two, then one beat, latency three.
// Notes:   The core read port returns a word built from bank and column.
`timescale 1ns/1ps
`default_nettype none
`include "sdpci_map.svh"

module sdpci_tb_top
  import sdpci_pkg::*;
();
  logic                     clk;
  logic                     rst_n;
  sdpci_pins_t              pins;
  logic [`SDPCI_DQ_W-1:0]   dq_wire;
  logic [`SDPCI_DQ_W-1:0]   dq_out;
  logic [`SDPCI_DQ_W-1:0]   core_rd_data;
  logic [`SDPCI_LANES-1:0]  dq_oe;
  sdpci_core_t              core;
  logic [`SDPCI_MR_W-1:0]   mode_reg;
  sdpci_pwr_t               pwr_state;
  logic [`SDPCI_BANKS-1:0]  bank_open;
  int                       n_errors;
  int                       checked;

  assign core_rd_data = {3'h5, core.bank, core.col, 2'h2};

  sdpci_ctl_model ctl (.clk(clk), .pins(pins), .dq_dev(dq_out), .dq_oe(dq_oe),
                       .dq_wire(dq_wire));

  sdpci_top DUT (.clk(clk), .rst_n(rst_n), .pins(pins), .dq_in(dq_wire), .dq_out(dq_out),
                 .dq_oe(dq_oe), .core(core), .core_rd_data(core_rd_data),
                 .mode_reg(mode_reg), .pwr_state(pwr_state), .bank_open(bank_open));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : chk

  task automatic nop(input logic cke);
    ctl.issue(cke, `SDPCI_CMD_NOP, 2'h0, 13'h0000, 2'h0);
  endtask : nop

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic s_mode_act;
    ctl.issue(1'b1, `SDPCI_CMD_LMR, 2'h2, 13'h0001, 2'h0);
    ctl.issue(1'b1, `SDPCI_CMD_ACT, 2'h1, 13'h1abc, 2'h0);
    chk(mode_reg, 32'h4001, "mode load");
    ctl.issue(1'b1, 4'hb, 2'h2, 13'h0000, 2'h0);
    chk(bank_open, 32'h2, "activate");
    nop(1'b1);
    chk(bank_open, 32'h2, "deselected activate");
  endtask : s_mode_act

  // Second beat runs while deselected, with the other lane masked.
  task automatic s_write;
    ctl.issue(1'b1, `SDPCI_CMD_WR, 2'h1, 13'h1bff, 2'h1);
    ctl.data(1'b1, 16'ha55a);
    ctl.issue(1'b1, 4'hf, 2'h0, 13'h0000, 2'h2);
    ctl.data(1'b1, 16'h3cc3);
    chk({core.wr_en, core.bank, core.row, core.col}, {1'b1, 2'h1, 13'h1abc, 9'h1ff},
        "write beat one");
    chk({core.wr_data[15:8], core.wr_be}, {8'ha5, 2'h2}, "write lane one");
    nop(1'b1);
    ctl.data(1'b0, 16'h0000);
    chk({core.wr_en, core.col, core.wr_data[7:0], core.wr_be}, {1'b1, 9'h000, 8'hc3, 2'h1},
        "write beat two");
    nop(1'b1);
    chk(core.wr_en, 32'h0, "write end");
  endtask : s_write

  task automatic s_read;
    logic [15:0] e1;
    logic [15:0] e2;
    e1 = {3'h5, 2'h1, 9'h010, 2'h2};
    e2 = {3'h5, 2'h1, 9'h011, 2'h2};
    ctl.issue(1'b1, `SDPCI_CMD_RD, 2'h1, 13'h0410, 2'h1);
    nop(1'b1);
    chk({core.rd_en, core.bank, core.col}, {1'b1, 2'h1, 9'h010}, "read beat one");
    nop(1'b1);
    chk({core.rd_en, core.col}, {1'b1, 9'h011}, "read beat two");
    chk({dq_oe, dq_wire}, {2'h3, e1}, "read out one");
    nop(1'b1);
    chk({dq_oe, dq_wire[15:8]}, {2'h2, e2[15:8]}, "read out two");
    nop(1'b1);
    chk({bank_open, dq_oe}, 32'h0, "auto precharge");
  endtask : s_read

  task automatic s_precharge;
    ctl.issue(1'b1, `SDPCI_CMD_ACT, 2'h0, 13'h0005, 2'h0);
    ctl.issue(1'b1, `SDPCI_CMD_ACT, 2'h2, 13'h0006, 2'h0);
    ctl.issue(1'b1, `SDPCI_CMD_PRE, 2'h0, 13'h0000, 2'h0);
    chk(bank_open, 32'h5, "two banks open");
    ctl.issue(1'b1, `SDPCI_CMD_ACT, 2'h1, 13'h0007, 2'h0);
    chk(bank_open, 32'h4, "single precharge");
    ctl.issue(1'b1, `SDPCI_CMD_PRE, 2'h0, 13'h0400, 2'h0);
    nop(1'b1);
    chk(bank_open, 32'h0, "all precharge");
  endtask : s_precharge

  task automatic s_power;
    nop(1'b0);
    ctl.issue(1'b0, `SDPCI_CMD_ACT, 2'h3, 13'h0000, 2'h0);
    chk(pwr_state, PWR_PRE_PD, "precharge power-down");
    nop(1'b1);
    chk({bank_open, dq_oe}, 32'h0, "inputs ignored");
    nop(1'b1);
    chk(pwr_state, PWR_RUN, "power-down exit");
    ctl.issue(1'b1, `SDPCI_CMD_REF, 2'h0, 13'h0000, 2'h0);
    ctl.issue(1'b0, `SDPCI_CMD_REF, 2'h0, 13'h0000, 2'h0);
    chk(core.ref_en, 32'h1, "refresh pulse");
    nop(1'b0);
    chk(pwr_state, PWR_SELF_REF, "self refresh");
    nop(1'b1);
    ctl.issue(1'b1, `SDPCI_CMD_ACT, 2'h3, 13'h0009, 2'h0);
    chk(pwr_state, PWR_RUN, "self refresh exit");
    nop(1'b0);
    nop(1'b0);
    chk(pwr_state, PWR_ACT_PD, "active power-down");
    nop(1'b1);
    ctl.issue(1'b1, `SDPCI_CMD_RD, 2'h3, 13'h0000, 2'h0);
    chk(pwr_state, PWR_RUN, "active exit");
    ctl.issue(1'b0, 4'hf, 2'h0, 13'h0000, 2'h0);
    nop(1'b1);
    chk(pwr_state, PWR_SUSPEND, "clock suspend");
    repeat (6) nop(1'b1);
    chk({pwr_state, dq_oe}, 32'h0, "suspend drained");
    ctl.issue(1'b1, `SDPCI_CMD_PRE, 2'h0, 13'h0400, 2'h0);
  endtask : s_power

  // Read latency three: one beat, upper lane masked with the command.
  task automatic s_cl3;
    logic [15:0] e;
    e = {3'h5, 2'h2, 9'h005, 2'h2};
    ctl.issue(1'b1, `SDPCI_CMD_LMR, 2'h0, 13'h0030, 2'h0);
    ctl.issue(1'b1, `SDPCI_CMD_ACT, 2'h2, 13'h0123, 2'h0);
    ctl.issue(1'b1, `SDPCI_CMD_RD, 2'h2, 13'h0005, 2'h2);
    nop(1'b1);
    chk({core.rd_en, core.row, core.col, dq_oe}, {1'b1, 13'h0123, 9'h005, 2'h0},
        "cl3 issue");
    nop(1'b1);
    chk(dq_oe, 32'h0, "cl3 wait");
    nop(1'b1);
    chk({dq_oe, dq_wire[7:0]}, {2'h1, e[7:0]}, "cl3 data");
    nop(1'b1);
    chk(dq_oe, 32'h0, "cl3 end");
  endtask : s_cl3

  // ----------------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    n_errors = 0;
    checked = 0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk({pwr_state, mode_reg, bank_open}, 32'h0, "reset state");
    s_mode_act();
    s_write();
    s_read();
    s_precharge();
    s_power();
    s_cl3();
    end_sim();
  end

  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    $display("MISMATCH %0t timeout", $time);
    end_sim();
  end
endmodule : sdpci_tb_top
`default_nettype wire
